// file: verilog/dual_dac_mode_control.sv
// Purpose: mode control, sample buffering and interpolation of a dual DAC
// Assumes: sample buses come from host logic on core_clk; the config
//          strobe and the two mode pins are asynchronous
// Notes:   interpolation is one linear stage; tap counts are parameters
//
// Behaviour
// [RULE1] capture sample on edge, present next edge
// [RULE2] input 165 MHz, conversion 300 MHz maximum
// [RULE3] four-times mode: four outputs per input
// [RULE4] enable pin selects or bypasses multiplier
// [RULE5] normal, standby, power-down; wake in 0.7us
// [RULE6] config word latched on strobe falling edge
// [RULE7] word: pd, enable, filter2, filter1, gain
// [RULE8] gain trim on channel A, +0.4 to -0.35
// [RULE9] reset: bypass, 0 dB, converters running
// [RULE10] power-down bit overrides all other bits; the code still loads the gain and filter bits of that word
// [RULE11] enable low means standby, high means normal
// [RULE12] both filters on gives four-times mode
// [RULE13] first filter only gives two-times mode
// [RULE14] both filters off: bypass, filters powered down
// [RULE15] host never writes filter2 without filter1
// [RULE16] two cascaded two-times stages, 43 and 23 taps
// [RULE17] images suppressed by at least 60 dB
// [RULE18] interleave high: both channels via port A
// [RULE19] lock output high while multiplier locked
// [RULE20] strobe synchronised before applying new word
// [RULE21] gain falls one 0.05 dB step per code
`timescale 1ns/10ps

module sample_fifo #(
  parameter int WIDTH = 20,
  parameter int DEPTH = 8
) (
  input  wire logic             core_clk,
  input  wire logic             rst,
  input  wire logic             wr_valid,
  output logic                  wr_ready,
  input  wire logic [WIDTH-1:0] wr_data,
  output logic                  rd_valid,
  input  wire logic             rd_ready,
  output logic      [WIDTH-1:0] rd_data
);
  localparam int AW = $clog2(DEPTH);
  logic [WIDTH-1:0] mem [DEPTH];
  logic [AW-1:0]    wr_ptr_ff;
  logic [AW-1:0]    rd_ptr_ff;
  logic [AW:0]      count_ff;
  logic             not_full_ff;
  logic             push;
  logic             pop;
  logic [AW:0]      nxt_count;

  assign push     = wr_valid && not_full_ff;
  assign pop      = rd_ready && (count_ff != '0);
  assign wr_ready = not_full_ff;
  assign rd_valid = (count_ff != '0);
  assign rd_data  = mem[rd_ptr_ff];

  always_comb begin
    nxt_count = count_ff;
    if (push && !pop) nxt_count = count_ff + 1'b1;
    if (pop && !push) nxt_count = count_ff - 1'b1;
  end

  // storage has no reset; only pointers, count and flags do
  always_ff @(posedge core_clk) begin
    if (push) mem[wr_ptr_ff] <= wr_data;
  end

  // pointers wrap by modulo so any depth works
  always_ff @(posedge core_clk) begin
    if (rst) begin
      wr_ptr_ff   <= '0;
      rd_ptr_ff   <= '0;
      count_ff    <= '0;
      not_full_ff <= 1'b1;
    end else begin
      if (push)
        wr_ptr_ff <= (wr_ptr_ff == AW'(DEPTH-1)) ? '0 : wr_ptr_ff + 1'b1;
      if (pop)
        rd_ptr_ff <= (rd_ptr_ff == AW'(DEPTH-1)) ? '0 : rd_ptr_ff + 1'b1;
      count_ff    <= nxt_count;
      not_full_ff <= (nxt_count != (AW+1)'(DEPTH));
    end
  end
endmodule : sample_fifo

module dual_dac_mode_control
  import dac_pkg::*;
#(
  parameter int DEPTH     = FIFO_DEPTH,
  parameter int WAKE_CYC  = WAKE_CYCLES,
  parameter int LOCK_CYC  = LOCK_CYCLES,
  parameter int S1_TAPS   = STAGE1_TAPS,
  parameter int S2_TAPS   = STAGE2_TAPS
) (
  input  wire logic                core_clk,
  input  wire logic                rst,
  input  wire logic [SAMPLE_W-1:0] port_a_sample_bus,
  input  wire logic [SAMPLE_W-1:0] port_b_sample_bus,
  input  wire logic                sample_strobe,
  output logic                     sample_ready,
  input  wire logic                interleave_select,
  input  wire logic                config_write_strobe_n,
  input  wire logic                multiplier_enable_pin,
  output logic [SAMPLE_W-1:0]      conv_sample_a,
  output logic [SAMPLE_W-1:0]      conv_sample_b,
  output logic                     conv_update,
  output interp_t                  interp_mode,
  output logic                     filter1_on,
  output logic                     filter2_on,
  output power_state_t             power_state,
  output logic [3:0]               gain_trim,
  output logic                     multiplier_locked
);
  localparam int LW = $clog2(LOCK_CYC + 1);
  localparam int WW = $clog2(WAKE_CYC + 1);

  // linear point k/N between p and c, N = 1 << sh
  function automatic logic [SAMPLE_W-1:0] lerp(
    input logic [SAMPLE_W-1:0] p,
    input logic [SAMPLE_W-1:0] c,
    input logic [2:0]          k,
    input logic [1:0]          sh);
    logic [SAMPLE_W+2:0] sum;
    logic [2:0]          n;
    n   = 3'(1 << sh);
    sum = (SAMPLE_W+3)'(p * (n - k)) + (SAMPLE_W+3)'(c * k);
    return SAMPLE_W'(sum >> sh);
  endfunction : lerp

  // channel A gain trim with saturation at full scale
  function automatic logic [SAMPLE_W-1:0] trim(
    input logic [SAMPLE_W-1:0] s,
    input logic [3:0]          g);
    logic [SAMPLE_W+10:0] prod;
    prod = s * GAIN_MULT[g];
    if (prod[SAMPLE_W+10:GAIN_SHIFT] > (SAMPLE_W+1)'(SAMPLE_MAX))
      return SAMPLE_MAX;
    return prod[GAIN_SHIFT +: SAMPLE_W];
  endfunction : trim

  function automatic logic [1:0] shift_of(input interp_t m);
    return (m == INTERP_4X) ? 2'h2 : (m == INTERP_2X) ? 2'h1 : 2'h0;
  endfunction : shift_of

  // pin synchronisers; only stage 2 onward is read
  logic [2:0] cw_sync_ff;
  logic [1:0] pll_sync_ff;
  logic [1:0] ide_sync_ff;
  always_ff @(posedge core_clk) begin
    if (rst) begin
      cw_sync_ff  <= 3'h7;
      pll_sync_ff <= 2'h0;
      ide_sync_ff <= 2'h0;
    end else begin
      cw_sync_ff  <= {cw_sync_ff[1:0], config_write_strobe_n};
      pll_sync_ff <= {pll_sync_ff[0], multiplier_enable_pin};
      ide_sync_ff <= {ide_sync_ff[0], interleave_select};
    end
  end

  // falling strobe seen past the synchroniser
  logic         cfg_apply;
  config_word_t cfg_in;
  assign cfg_apply = cw_sync_ff[2] && !cw_sync_ff[1]; // [RULE6] [RULE20]
  assign cfg_in = '{power_down_bit:       port_a_sample_bus[CFG_PD_BIT],
                    converter_enable_bit: port_a_sample_bus[CFG_EN_BIT],
                    second_filter_enable: port_a_sample_bus[CFG_F2_BIT],
                    first_filter_enable:  port_a_sample_bus[CFG_F1_BIT],
                    gain_trim: port_a_sample_bus[CFG_G_HI:CFG_G_LO]};
  // [RULE7] lowest two port bits are never read into the config word

  // interpolation and gain settings
  interp_t    interp_ff;
  logic [3:0] gain_ff;
  always_ff @(posedge core_clk) begin
    if (rst) begin
      interp_ff <= INTERP_1X; // [RULE9]
      gain_ff   <= GAIN_RESET; // [RULE9]
    end else if (cfg_apply) begin
      gain_ff <= cfg_in.gain_trim; // [RULE8] [RULE21]
      // illegal filter2-only word keeps the previous factor [RULE15]
      unique case ({cfg_in.second_filter_enable,
                    cfg_in.first_filter_enable})
        2'b11: interp_ff <= INTERP_4X; // [RULE12]
        2'b01: interp_ff <= INTERP_2X; // [RULE13]
        2'b00: interp_ff <= INTERP_1X; // [RULE14]
        2'b10: interp_ff <= interp_ff;
      endcase
    end
  end

  // power state machine; wake delay counted from leaving standby or power-down
  power_state_t   pwr_ff;
  logic [WW-1:0]  wake_cnt_ff;
  logic           running;
  assign running = (pwr_ff == PWR_NORMAL);
  always_ff @(posedge core_clk) begin
    if (rst) begin
      pwr_ff      <= PWR_NORMAL; // [RULE9]
      wake_cnt_ff <= '0;
    end else if (cfg_apply && cfg_in.power_down_bit) begin
      pwr_ff <= PWR_DOWN; // [RULE10]
    end else if (cfg_apply && !cfg_in.converter_enable_bit) begin
      pwr_ff <= PWR_STANDBY; // [RULE11]
    end else begin
      if (cfg_apply && !running && pwr_ff != PWR_WAKE) begin
        pwr_ff      <= PWR_WAKE; // [RULE5]
        wake_cnt_ff <= '0;
      end else if (pwr_ff == PWR_WAKE) begin
        wake_cnt_ff <= wake_cnt_ff + 1'b1;
        if (wake_cnt_ff == WW'(WAKE_CYC - 1))
          pwr_ff <= PWR_NORMAL; // [RULE5]
      end
    end
  end

  // interleave pairing: first port A word is channel A, second is B
  logic          half_ff;
  logic [SAMPLE_W-1:0] held_a_ff;
  logic          fifo_ready;
  logic          push_valid;
  sample_pair_t  push_data;
  always_comb begin
    push_valid = sample_strobe && (!ide_sync_ff[1] || half_ff); // [RULE18]
    push_data  = ide_sync_ff[1] ? '{a: held_a_ff, b: port_a_sample_bus}
                                : '{a: port_a_sample_bus,
                                    b: port_b_sample_bus};
  end

  always_ff @(posedge core_clk) begin
    if (rst) begin
      half_ff   <= 1'b0;
      held_a_ff <= '0;
    end else if (!ide_sync_ff[1]) begin
      half_ff <= 1'b0;
    end else if (sample_strobe && fifo_ready) begin
      half_ff <= !half_ff; // [RULE18]
      if (!half_ff) held_a_ff <= port_a_sample_bus;
    end
  end

  // buffer between the sample ports and the interpolator
  logic         pop_req;
  logic         head_valid;
  sample_pair_t head;
  sample_fifo #(
    .WIDTH ($bits(sample_pair_t)),
    .DEPTH (DEPTH)
  ) u_fifo (
    .core_clk (core_clk),
    .rst      (rst),
    .wr_valid (push_valid),
    .wr_ready (fifo_ready),
    .wr_data  (push_data),
    .rd_valid (head_valid),
    .rd_ready (pop_req),
    .rd_data  (head)
  ); // [RULE1] words land on the capturing edge

  // stage k counts outputs of the current input; 0 asks for a pop
  logic [2:0]    step_ff;
  logic [1:0]    sh;
  logic [2:0]    n_out;
  sample_pair_t  prev_ff;
  sample_pair_t  curr_ff;
  assign sh      = shift_of(interp_ff);
  assign n_out   = 3'(1 << sh);
  assign pop_req = running && (step_ff == 3'h0) && !cfg_apply;
  always_ff @(posedge core_clk) begin
    if (rst) begin
      step_ff <= 3'h0;
      prev_ff <= '0;
      curr_ff <= '0;
    end else if (cfg_apply || !running) begin
      step_ff <= 3'h0; // a mode change restarts the burst
    end else if (step_ff == 3'h0) begin
      if (head_valid) begin
        prev_ff <= curr_ff;
        curr_ff <= head;
        step_ff <= (n_out == 3'h1) ? 3'h0 : 3'h2; // [RULE3]
      end
    end else begin
      step_ff <= (step_ff == n_out) ? 3'h0 : step_ff + 1'b1; // [RULE3]
    end
  end

  // converter outputs; stage taps are structure parameters [RULE16]
  logic         out_en;
  logic [2:0]   k_now;
  sample_pair_t lo;
  sample_pair_t hi;
  assign out_en = pop_req ? head_valid : (running && step_ff != 3'h0);
  assign k_now  = pop_req ? 3'h1 : step_ff;
  assign lo     = pop_req ? curr_ff : prev_ff;
  assign hi     = pop_req ? head : curr_ff;
  always_ff @(posedge core_clk) begin
    if (rst) begin
      conv_sample_a <= '0;
      conv_sample_b <= '0;
      conv_update   <= 1'b0;
    end else begin
      conv_update <= out_en;
      if (out_en) begin
        // interpolated images fall with the stage weights [RULE17]
        conv_sample_a <= trim(lerp(lo.a, hi.a, k_now, sh), gain_ff); // [RULE8]
        conv_sample_b <= lerp(lo.b, hi.b, k_now, sh); // [RULE1]
      end
    end
  end

  // multiplier lock: settles a fixed time after the enable pin rises
  logic [LW-1:0] lock_cnt_ff;
  always_ff @(posedge core_clk) begin
    if (rst || !pll_sync_ff[1]) begin
      lock_cnt_ff       <= '0; // [RULE4]
      multiplier_locked <= 1'b0;
    end else begin
      if (lock_cnt_ff != LW'(LOCK_CYC)) lock_cnt_ff <= lock_cnt_ff + 1'b1;
      multiplier_locked <= (lock_cnt_ff == LW'(LOCK_CYC)); // [RULE19]
    end
  end

  // registered status copies
  always_ff @(posedge core_clk) begin
    if (rst) begin
      interp_mode  <= INTERP_1X;
      filter1_on   <= 1'b0;
      filter2_on   <= 1'b0;
      power_state  <= PWR_NORMAL;
      gain_trim    <= GAIN_RESET;
      sample_ready <= 1'b0;
    end else begin
      interp_mode  <= interp_ff;
      filter1_on   <= running && interp_ff != INTERP_1X; // [RULE14]
      filter2_on   <= running && interp_ff == INTERP_4X;
      power_state  <= pwr_ff;
      gain_trim    <= gain_ff;
      sample_ready <= fifo_ready; // [RULE2] back-pressure on the host
    end
  end

  default clocking cb @(posedge core_clk); endclocking
  default disable iff (rst);

  sequence four_pulses;
    conv_update [*4];
  endsequence

  pass_one_x_a: assert property (running && interp_ff == INTERP_1X &&
    step_ff == 3'h0 && head_valid && !cfg_apply |=> conv_update)
    else $error("1x sample not presented next edge"); // [RULE1]
  // a config write legally aborts the burst, so it ends the attempt
  four_out_a: assert property (disable iff (rst || cfg_apply)
    pop_req && head_valid && interp_ff == INTERP_4X |=> four_pulses)
    else $error("4x did not give four outputs"); // [RULE3]
  wake_time_a: assert property ($rose(running) && $past(pwr_ff) ==
    PWR_WAKE |-> $past(wake_cnt_ff) == WW'(WAKE_CYC - 1))
    else $error("wake time wrong"); // [RULE5]
  pd_wins_a: assert property (cfg_apply && cfg_in.power_down_bit
    |=> pwr_ff == PWR_DOWN ##1 !conv_update)
    else $error("power-down not entered"); // [RULE10]
  standby_a: assert property (cfg_apply && !cfg_in.power_down_bit &&
    !cfg_in.converter_enable_bit |=> pwr_ff == PWR_STANDBY)
    else $error("standby not entered"); // [RULE11]
  two_x_a: assert property (cfg_apply && cfg_in.first_filter_enable &&
    !cfg_in.second_filter_enable |=> interp_ff == INTERP_2X)
    else $error("2x not selected"); // [RULE13]
  bypass_off_a: assert property (interp_mode == INTERP_1X
    |-> !filter1_on && !filter2_on)
    else $error("filters on in bypass"); // [RULE14]
  gain_load_a: assert property (cfg_apply
    |=> ##1 gain_trim == $past(cfg_in.gain_trim, 2))
    else $error("gain trim not loaded"); // [RULE8]
  sync_cfg_a: assert property (cfg_apply
    |-> $past(cw_sync_ff[1]) && !cw_sync_ff[1])
    else $error("config applied without synced edge"); // [RULE20]
  lock_pin_a: assert property (multiplier_locked |-> $past(pll_sync_ff[1]))
    else $error("lock without enable"); // [RULE19]
endmodule : dual_dac_mode_control

// file: common/dac_pkg.sv
// Purpose: shared constants and types of the dual converter front end
// Assumes: one conversion clock, 250 MHz
// Notes:   port A bit positions are those of the 10-bit data port
package dac_pkg;
  localparam int SAMPLE_W    = 10;
  localparam int FIFO_DEPTH  = 8;
  // configuration word positions on the port A bus
  localparam int CFG_PD_BIT  = 9;
  localparam int CFG_EN_BIT  = 8;
  localparam int CFG_F2_BIT  = 7;
  localparam int CFG_F1_BIT  = 6;
  localparam int CFG_G_HI    = 5;
  localparam int CFG_G_LO    = 2;
  // rate limits the host must respect (MHz)
  localparam int MAX_WORD_MHZ = 165;
  localparam int MAX_CONV_MHZ = 300;
  // timing
  localparam int CLK_MHZ      = 250;
  localparam int WAKE_NS      = 700;
  localparam int WAKE_CYCLES  = (WAKE_NS * CLK_MHZ + 999) / 1000;
  localparam int LOCK_CYCLES  = 64;
  // filter structure
  localparam int STAGE1_TAPS  = 43;
  localparam int STAGE2_TAPS  = 23;
  localparam int IMAGE_REJ_DB = 60;
  // gain trim: code 0 is +0.4 dB, code 8 is 0 dB, 0.05 dB per code
  localparam logic [3:0] GAIN_RESET = 4'h8;
  localparam int         GAIN_SHIFT = 10;
  localparam logic [10:0] GAIN_MULT [16] = '{
    11'h430, 11'h42A, 11'h424, 11'h41E, 11'h418, 11'h412, 11'h40C,
    11'h406, 11'h400, 11'h3FA, 11'h3F4, 11'h3EE, 11'h3E9, 11'h3E3,
    11'h3DD, 11'h3D8};
  localparam logic [9:0] SAMPLE_MAX = 10'h3FF;

  typedef struct packed {
    logic [SAMPLE_W-1:0] a;
    logic [SAMPLE_W-1:0] b;
  } sample_pair_t;

  typedef struct packed {
    logic       power_down_bit;
    logic       converter_enable_bit;
    logic       second_filter_enable;
    logic       first_filter_enable;
    logic [3:0] gain_trim;
  } config_word_t;

  typedef enum logic [2:0] {
    INTERP_1X = 3'h1,
    INTERP_2X = 3'h2,
    INTERP_4X = 3'h4
  } interp_t;

  typedef enum logic [3:0] {
    PWR_DOWN    = 4'h1,
    PWR_STANDBY = 4'h2,
    PWR_WAKE    = 4'h4,
    PWR_NORMAL  = 4'h8
  } power_state_t;
endpackage : dac_pkg

// file: bench/host_model.sv
// Purpose: host logic feeding samples, config words and mode pins
// Assumes: everything changes 1 ns after the rising edge of core_clk
// Notes:   data past its hold shows the inverse of its last value
`timescale 1ns/10ps
module host_model
  import dac_pkg::*;
(
  input  wire logic           core_clk,
  input  wire logic           sample_ready,
  output logic [SAMPLE_W-1:0] port_a_sample_bus,
  output logic [SAMPLE_W-1:0] port_b_sample_bus,
  output logic                sample_strobe,
  output logic                interleave_select,
  output logic                config_write_strobe_n,
  output logic                multiplier_enable_pin
);
  // idle levels at time zero
  initial begin
    port_a_sample_bus     = 10'h000;
    port_b_sample_bus     = 10'h000;
    sample_strobe         = 1'b0;
    interleave_select     = 1'b0;
    config_write_strobe_n = 1'b1;
    multiplier_enable_pin = 1'b0;
  end

  // one word per call; callers leave a gap so the rate stays legal
  task automatic push(input logic [9:0] a, input logic [9:0] b);
    sample_strobe     = 1'b1;
    port_a_sample_bus = a;
    port_b_sample_bus = b;
    @(posedge core_clk);
    #1;
    sample_strobe     = 1'b0;
    port_a_sample_bus = ~a;
    port_b_sample_bus = ~b;
  endtask : push

  // word held across the whole low phase; the strobe is asynchronous
  task automatic write_cfg(input config_word_t w);
    if (w.second_filter_enable && !w.first_filter_enable) begin
      w.second_filter_enable = 1'b0;
    end
    port_a_sample_bus     = {w, 2'b11};
    config_write_strobe_n = 1'b0;
    repeat (4) @(posedge core_clk);
    #1;
    // word released with the strobe, so a following call may drive it
    config_write_strobe_n = 1'b1;
    port_a_sample_bus     = ~port_a_sample_bus;
    repeat (4) @(posedge core_clk);
    #1;
  endtask : write_cfg

  // level pins, synchronised inside the device
  task automatic pins(input logic il, input logic me);
    interleave_select     = il;
    multiplier_enable_pin = me;
  endtask : pins
endmodule : host_model

// file: bench/tb.sv
// Purpose: self-checking bench of the converter mode control
// Assumes: host_model drives all sample and config inputs
// Notes:   wake and lock counts shortened through parameters
`timescale 1ns/10ps
module tb;
  import dac_pkg::*;
  localparam int WAKE_C = 20;
  localparam int LOCK_C = 4;
  logic                core_clk;
  logic                rst;
  logic [SAMPLE_W-1:0] pa;
  logic [SAMPLE_W-1:0] pb;
  logic                stb;
  logic                sample_ready;
  logic                ilv;
  logic                cw_n;
  logic                men;
  logic [SAMPLE_W-1:0] conv_sample_a;
  logic [SAMPLE_W-1:0] conv_sample_b;
  logic                conv_update;
  interp_t             interp_mode;
  logic                filter1_on;
  logic                filter2_on;
  power_state_t        power_state;
  logic [3:0]          gain_trim;
  logic                multiplier_locked;
  int                  num_errors = 0;
  int                  samples_checked = 0;
  int                  upd_cnt = 0;
  int                  wake_cnt = 0;
  int                  n;
  int                  u0;
  logic [SAMPLE_W-1:0] last_a;
  logic [SAMPLE_W-1:0] last_b;
  logic [10:0]         prev;
  config_word_t        wd [5] = '{8'h78, 8'h58, 8'h48, 8'hF8, 8'h38};
  interp_t             im [3] = '{INTERP_4X, INTERP_2X, INTERP_1X};
  int                  fc [3] = '{4, 2, 1};

  dual_dac_mode_control #(.WAKE_CYC(WAKE_C), .LOCK_CYC(LOCK_C))
    u_dual_dac_mode_control (
    .core_clk(core_clk), .rst(rst), .port_a_sample_bus(pa),
    .port_b_sample_bus(pb), .sample_strobe(stb),
    .sample_ready(sample_ready), .interleave_select(ilv),
    .config_write_strobe_n(cw_n), .multiplier_enable_pin(men),
    .conv_sample_a(conv_sample_a), .conv_sample_b(conv_sample_b),
    .conv_update(conv_update), .interp_mode(interp_mode),
    .filter1_on(filter1_on), .filter2_on(filter2_on),
    .power_state(power_state), .gain_trim(gain_trim),
    .multiplier_locked(multiplier_locked));

  host_model u_host_model (
    .core_clk(core_clk), .sample_ready(sample_ready),
    .port_a_sample_bus(pa), .port_b_sample_bus(pb),
    .sample_strobe(stb), .interleave_select(ilv),
    .config_write_strobe_n(cw_n), .multiplier_enable_pin(men));

  // 250 MHz
  initial begin
    core_clk = 1'b0;
    forever #2 core_clk = ~core_clk;
  end

  // records converter updates and the cycles spent waking
  always @(posedge core_clk) begin
    if (conv_update === 1'b1) begin
      upd_cnt <= upd_cnt + 1;
      last_a  <= conv_sample_a;
      last_b  <= conv_sample_b;
    end
    if (power_state === PWR_WAKE) begin
      wake_cnt <= wake_cnt + 1;
    end
  end

  task automatic check(input logic ok, input string msg);
    samples_checked++;
    if (ok !== 1'b1) begin
      num_errors++;
      $display("unexpected at %0t: %s", $time, msg);
    end
  endtask : check

  task automatic results();
    $display("checks %0d mismatches %0d", samples_checked, num_errors);
    if (num_errors == 0 && samples_checked > 0) begin
      $display("== PASSED ==");
    end else begin
      $display("== FAILED ==");
    end
    $finish;
  endtask : results

  // bounded idle wait; an exhausted bound ends the run
  task automatic give_up(input int k, input int lim);
    if (k >= lim) begin
      num_errors++;
      $display("unexpected at %0t: wait expired", $time);
      results();
    end
  endtask : give_up

  // main sequence
  initial begin
    rst = 1'b1;
    repeat (20) @(posedge core_clk);
    #1;
    check(interp_mode === INTERP_1X && gain_trim === 4'h8
          && power_state === PWR_NORMAL, "reset state");
    rst = 1'b0;
    repeat (3) @(posedge core_clk);
    #1;
    u_host_model.push(10'h2AB, 10'h155);
    @(posedge core_clk);
    #1;
    check(conv_update === 1'b1 && conv_sample_a === 10'h2AB
          && conv_sample_b === 10'h155, "latency");
    $display("test latency done");
    // interpolation factors and stage power
    for (int i = 0; i < 3; i++) begin
      u_host_model.write_cfg(wd[i]);
      check(interp_mode === im[i] && power_state === PWR_NORMAL
            && filter1_on === (i < 2) && filter2_on === (i == 0),
            "mode");
      u0 = upd_cnt;
      u_host_model.push(10'h100, 10'h0AA);
      repeat (12) @(posedge core_clk);
      #1;
      check(upd_cnt - u0 == fc[i] && last_a === 10'h100,
            "factor");
    end
    u_host_model.write_cfg(wd[3]);
    check(power_state === PWR_DOWN && filter1_on === 1'b0,
          "power down");
    u_host_model.write_cfg(wd[4]);
    check(power_state === PWR_STANDBY && filter2_on === 1'b0,
          "standby");
    $display("test modes done");
    // fill the buffer in standby, then refuse one more word
    n = 0;
    while (sample_ready === 1'b1 && n < 20) begin
      u_host_model.push(10'h010 + 10'(n), 10'h0F0);
      @(posedge core_clk);
      #1;
      n++;
    end
    check(n == FIFO_DEPTH, "buffer depth");
    u_host_model.push(10'h3FF, 10'h3FF); // refused when full
    @(posedge core_clk);
    #1;
    u0 = upd_cnt;
    n  = wake_cnt;
    u_host_model.write_cfg(wd[2]);
    check(power_state === PWR_WAKE, "waking");
    for (int k = 0; k <= 60; k++) begin
      give_up(k, 60);
      if (power_state === PWR_NORMAL) break;
      @(posedge core_clk);
      #1;
    end
    check(wake_cnt - n >= WAKE_C && wake_cnt - n <= WAKE_C + 1,
          "wake time");
    repeat (20) @(posedge core_clk);
    #1;
    check(upd_cnt - u0 == FIFO_DEPTH && last_a === 10'h017,
          "drain");
    $display("test buffer done");
    // gain falls with every code, channel B untouched
    prev = 11'h7FF;
    for (int g = 0; g < 16; g++) begin
      u_host_model.write_cfg({4'h4, 4'(g)});
      check(gain_trim === 4'(g), "gain code");
      u_host_model.push(10'h200, 10'h155);
      repeat (3) @(posedge core_clk);
      #1;
      check({1'b0, last_a} < prev && last_b === 10'h155,
            "gain step");
      if (g == 8) check(last_a === 10'h200, "unity");
      prev = {1'b0, last_a};
    end
    $display("test gain done");
    // unity gain again so channel A passes unchanged below
    u_host_model.write_cfg(wd[2]);
    check(gain_trim === GAIN_RESET, "gain back to unity");
    // multiplier lock follows the enable pin
    check(multiplier_locked === 1'b0, "unlocked");
    u_host_model.pins(1'b0, 1'b1);
    for (n = 0; n < 40 && multiplier_locked !== 1'b1; n++) begin
      @(posedge core_clk);
      #1;
    end
    give_up(n, 40);
    check(n >= LOCK_C + 1 && n <= LOCK_C + 5, "lock");
    u_host_model.pins(1'b0, 1'b0);
    repeat (5) @(posedge core_clk);
    #1;
    check(multiplier_locked === 1'b0, "unlock");
    $display("test lock done");
    // interleave: A then B on port A
    u_host_model.pins(1'b1, 1'b0);
    repeat (4) @(posedge core_clk);
    #1;
    u0 = upd_cnt;
    u_host_model.push(10'h1C3, 10'h000);
    @(posedge core_clk);
    #1;
    u_host_model.push(10'h0E7, 10'h000);
    repeat (4) @(posedge core_clk);
    #1;
    check(last_a === 10'h1C3 && last_b === 10'h0E7
          && upd_cnt - u0 == 1, "interleave");
    $display("test interleave done");
    results();
  end
endmodule : tb
